// [rtl/htcef_defs.svh]
// Command codes, bit positions and reset values for the transfer count and event flag block.
// Assumes a 16-bit host data path and one 25 MHz system clock.
`ifndef HTCEF_DEFS_SVH
`define HTCEF_DEFS_SVH

`define HTCEF_RD_DMA     8'h21
`define HTCEF_WR_DMA     8'ha1
`define HTCEF_RD_COUNT   8'h22
`define HTCEF_WR_COUNT   8'ha2
`define HTCEF_RD_FLAGS   8'h24
`define HTCEF_WR_FLAGS   8'ha4
`define HTCEF_RD_MASK    8'h25
`define HTCEF_WR_MASK    8'ha5

`define HTCEF_FLAG_SOF   0
`define HTCEF_FLAG_ATL   1
`define HTCEF_FLAG_EOT   2
`define HTCEF_FLAG_RSVD  3
`define HTCEF_FLAG_OPR   4
`define HTCEF_FLAG_SUSP  5
`define HTCEF_FLAG_CLK   6
`define HTCEF_NFLAGS     7

`define HTCEF_DMA_CNT_BIT 2
`define HTCEF_DMA_RUN_BIT 4
`define HTCEF_DMA_BITS    7

`define HTCEF_ZERO16     16'h0000
`define HTCEF_ZERO7      7'h00
`define HTCEF_ZERO9      9'h000
`define HTCEF_ZERO14     14'h0000

`endif

// [rtl/htcef_pkg.sv]
// Types shared by the transfer count and event flag block.
// Assumes the constants header is compiled alongside.
package htcef_pkg;

  typedef struct packed {
    logic        strobe;
    logic [7:0]  code;
    logic [15:0] wdata;
  } htcef_cmd_t;

  typedef struct packed {
    logic sof_mark;
    logic async_ready;
    logic core_event;
    logic sleep_entered;
    logic clk_ready;
  } htcef_evt_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_PIO     = 4'b0010,
    ST_DMA_CNT = 4'b0100,
    ST_DMA_EXT = 4'b1000
  } htcef_state_t;

endpackage

// [rtl/htcef_flag_bit.sv]
// One sticky event flag: set by hardware, cleared by a write of one.
// Assumes set and clear are single-cycle pulses on the same clock.
`timescale 1ns/1ns
`default_nettype none
module htcef_flag_bit (
  input  wire logic clock,    // System clock.
  input  wire logic reset,    // Asynchronous reset, active high.
  input  wire logic set_in,   // Event pulse.
  input  wire logic clr_in,   // Write-one-to-clear pulse.
  output logic      flag_reg  // Sticky flag.
);
  logic flag_next;

  // An event in the clearing cycle must not be lost, so set wins.
  always_comb begin
    flag_next = (flag_reg & ~clr_in) | set_in;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  set_wins_a: assert property (@(posedge clock) disable iff (reset) set_in |=> flag_reg)
    else $error("flag lost an event");
  clear_holds_a: assert property (@(posedge clock) disable iff (reset)
    (clr_in && !set_in) |=> !flag_reg)
    else $error("flag did not clear");
endmodule
`default_nettype wire

// [rtl/htcef_top.sv]
// Transfer byte counter and processor event flags with interrupt pin gating.
// Assumes the command port, events and irq_pin_on come from logic on the same clock.
// Summary of operation
// - DMA counter takes the byte count only when dma_count_use is set.
// - Count reached raises end event, sets flag 2 and signals fill state update.
// - Byte count read with code 22, written with code A2.
// - Byte count is 16 bits, read/write, reset to zero.
// - Flag drives interrupt pin only when masked in and irq_pin_on set.
// - Reads leave flags; writing a one clears that flag.
// - Flags read with code 24, written with code A4.
// - Flag 6 sets when the clock is ready after wake-up.
// - Flag 5 sets once the host controller has entered suspend.
// - Flag 4 sets when the controller core has pending events.
// - Flag 2 sets on internal or external end of transfer.
// - Flag 1 sets when async list data is ready.
// - Flag 0 sets at each start-of-frame 1 ms mark.
// - All mask bits are zero after reset.
// - With irq_pin_on clear the interrupt pin stays inactive.
// - dma_run clears itself when the DMA transfer completes.
`timescale 1ns/1ns
`default_nettype none
`include "htcef_defs.svh"
module htcef_top
  import htcef_pkg::*;
(
  input  wire logic        clock,            // 25 MHz system clock.
  input  wire logic        reset,            // Asynchronous reset, active high.
  input  wire htcef_cmd_t  cmd,              // Command strobe, code and write data.
  input  wire htcef_evt_t  evt,              // Event pulses from the controller.
  input  wire logic        irq_pin_on,       // Pin enable from hardware setup.
  input  wire logic        xfer_beat,        // One bus beat moved to or from buffer RAM.
  input  wire logic [1:0]  beat_bytes,       // Bytes moved in that beat.
  input  wire logic        ext_end_pin,      // External end-of-transfer pin, active high.
  output logic [15:0]      rd_data_reg,      // Read answer.
  output logic             rd_valid_reg,     // Read answer valid, one cycle.
  output logic             host_irq_pin_reg, // Interrupt pin level, active high.
  output logic             xfer_end_reg,     // End-of-transfer pulse.
  output logic             fill_update_reg,  // Buffer fill state update pulse.
  output logic             dma_run_reg       // DMA run bit.
);
  logic [15:0] count_reg, count_next;
  logic [15:0] remain_reg, remain_next;
  logic [6:0]  mask_reg, mask_next;
  logic [6:0]  dma_reg, dma_next;
  htcef_state_t state_reg, state_next;
  logic        end_pulse;
  logic [15:0] rd_data_next;
  logic        rd_valid_next, irq_next;
  logic [6:0]  flags, flag_set, flag_clr;
  logic        sync1_reg, sync2_reg, sync3_reg, ext_lvl_reg, ext_lvl_next;
  logic        ext_rise;
  logic        wr_cnt, wr_dma, wr_flg, wr_msk, last_beat;

  assign wr_cnt    = cmd.strobe && (cmd.code == `HTCEF_WR_COUNT);
  assign wr_dma    = cmd.strobe && (cmd.code == `HTCEF_WR_DMA);
  assign wr_flg    = cmd.strobe && (cmd.code == `HTCEF_WR_FLAGS);
  assign wr_msk    = cmd.strobe && (cmd.code == `HTCEF_WR_MASK);
  assign last_beat = xfer_beat && (remain_reg <= {`HTCEF_ZERO14, beat_bytes});
  assign dma_run_reg = dma_reg[`HTCEF_DMA_RUN_BIT];

  // External pin: the level moves only when the second and third stages agree.
  always_comb begin
    ext_lvl_next = (sync2_reg == sync3_reg) ? sync3_reg : ext_lvl_reg;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1_reg   <= 1'b0;
      sync2_reg   <= 1'b0;
      sync3_reg   <= 1'b0;
      ext_lvl_reg <= 1'b0;
    end else begin
      sync1_reg   <= ext_end_pin;
      sync2_reg   <= sync1_reg;
      sync3_reg   <= sync2_reg;
      ext_lvl_reg <= ext_lvl_next;
    end
  end

  assign ext_rise = ext_lvl_next && !ext_lvl_reg;

  // Transfer sequencing. A byte count or DMA write in the same cycle as a beat takes priority.
  always_comb begin
    count_next  = count_reg;
    remain_next = remain_reg;
    dma_next    = dma_reg;
    mask_next   = mask_reg;
    state_next  = state_reg;
    end_pulse   = 1'b0;
    if (wr_msk) begin
      mask_next = cmd.wdata[6:0];
    end
    if (wr_cnt) begin
      count_next  = cmd.wdata;
      remain_next = cmd.wdata;
      state_next  = (cmd.wdata != `HTCEF_ZERO16) ? ST_PIO : ST_IDLE;
    end else if (wr_dma) begin
      dma_next = cmd.wdata[6:0];
      if (!cmd.wdata[`HTCEF_DMA_RUN_BIT]) begin
        state_next = ST_IDLE;
      end else if (cmd.wdata[`HTCEF_DMA_CNT_BIT]) begin
        remain_next = count_reg;
        state_next  = (count_reg != `HTCEF_ZERO16) ? ST_DMA_CNT : ST_IDLE;
      end else begin
        state_next = ST_DMA_EXT;
      end
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_IDLE;
        end
        ST_PIO, ST_DMA_CNT: begin
          if (last_beat) begin
            end_pulse   = 1'b1;
            remain_next = `HTCEF_ZERO16;
            state_next  = ST_IDLE;
          end else if (xfer_beat) begin
            remain_next = remain_reg - {`HTCEF_ZERO14, beat_bytes};
          end
        end
        ST_DMA_EXT: begin
          if (ext_rise) begin
            end_pulse  = 1'b1;
            state_next = ST_IDLE;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
      if (end_pulse && (state_reg != ST_PIO)) begin
        dma_next[`HTCEF_DMA_RUN_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_reg       <= `HTCEF_ZERO16;
      remain_reg      <= `HTCEF_ZERO16;
      dma_reg         <= `HTCEF_ZERO7;
      mask_reg        <= `HTCEF_ZERO7;
      state_reg       <= ST_IDLE;
      xfer_end_reg    <= 1'b0;
      fill_update_reg <= 1'b0;
    end else begin
      count_reg       <= count_next;
      remain_reg      <= remain_next;
      dma_reg         <= dma_next;
      mask_reg        <= mask_next;
      state_reg       <= state_next;
      xfer_end_reg    <= end_pulse;
      fill_update_reg <= end_pulse;
    end
  end

  // Event flags; the reserved position is never built, so it reads zero.
  always_comb begin
    flag_set = `HTCEF_ZERO7;
    flag_set[`HTCEF_FLAG_SOF]  = evt.sof_mark;
    flag_set[`HTCEF_FLAG_ATL]  = evt.async_ready;
    flag_set[`HTCEF_FLAG_EOT]  = end_pulse;
    flag_set[`HTCEF_FLAG_OPR]  = evt.core_event;
    flag_set[`HTCEF_FLAG_SUSP] = evt.sleep_entered;
    flag_set[`HTCEF_FLAG_CLK]  = evt.clk_ready;
    flag_clr = wr_flg ? cmd.wdata[6:0] : `HTCEF_ZERO7;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `HTCEF_NFLAGS; gi++) begin : g_flag
      if (gi == `HTCEF_FLAG_RSVD) begin : g_rsvd
        assign flags[gi] = 1'b0;
      end else begin : g_bit
        htcef_flag_bit u_flag (
          .clock    (clock),
          .reset    (reset),
          .set_in   (flag_set[gi]),
          .clr_in   (flag_clr[gi]),
          .flag_reg (flags[gi])
        );
      end
    end
  endgenerate

  // Read answers and interrupt pin; unmapped codes get no answer.
  always_comb begin
    rd_data_next  = `HTCEF_ZERO16;
    rd_valid_next = 1'b0;
    irq_next      = irq_pin_on && ((flags & mask_reg) != `HTCEF_ZERO7);
    if (cmd.strobe) begin
      case (cmd.code)
        `HTCEF_RD_COUNT: begin
          rd_data_next  = count_reg;
          rd_valid_next = 1'b1;
        end
        `HTCEF_RD_FLAGS: begin
          rd_data_next  = {`HTCEF_ZERO9, flags};
          rd_valid_next = 1'b1;
        end
        `HTCEF_RD_MASK: begin
          rd_data_next  = {`HTCEF_ZERO9, mask_reg};
          rd_valid_next = 1'b1;
        end
        `HTCEF_RD_DMA: begin
          rd_data_next  = {`HTCEF_ZERO9, dma_reg};
          rd_valid_next = 1'b1;
        end
        default: begin
          rd_valid_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_data_reg      <= `HTCEF_ZERO16;
      rd_valid_reg     <= 1'b0;
      host_irq_pin_reg <= 1'b0;
    end else begin
      rd_data_reg      <= rd_data_next;
      rd_valid_reg     <= rd_valid_next;
      host_irq_pin_reg <= irq_next;
    end
  end

  sequence seq_count_done;
    (state_reg == ST_PIO || state_reg == ST_DMA_CNT) && last_beat
      && !wr_cnt && !wr_dma;
  endsequence

  sequence seq_end_seen;
    xfer_end_reg && fill_update_reg && flags[`HTCEF_FLAG_EOT];
  endsequence

  count_write_a: assert property (@(posedge clock) disable iff (reset)
    wr_cnt |=> count_reg == $past(cmd.wdata))
    else $error("byte count write not stored");
  count_read_a: assert property (@(posedge clock) disable iff (reset)
    (cmd.strobe && cmd.code == `HTCEF_RD_COUNT) |=> rd_valid_reg && rd_data_reg == count_reg)
    else $error("byte count read wrong");
  end_event_a: assert property (@(posedge clock) disable iff (reset)
    seq_count_done |=> seq_end_seen)
    else $error("count reached without end event");
  dma_autostop_a: assert property (@(posedge clock) disable iff (reset)
    (seq_count_done and state_reg == ST_DMA_CNT) |=> !dma_run_reg)
    else $error("dma run not cleared at end");
  ext_select_a: assert property (@(posedge clock) disable iff (reset)
    (wr_dma && cmd.wdata[`HTCEF_DMA_RUN_BIT] && !cmd.wdata[`HTCEF_DMA_CNT_BIT])
      |=> state_reg == ST_DMA_EXT)
    else $error("counter used without dma_count_use");
  read_keeps_a: assert property (@(posedge clock) disable iff (reset)
    (cmd.strobe && cmd.code == `HTCEF_RD_FLAGS && flags[`HTCEF_FLAG_SOF])
      |=> flags[`HTCEF_FLAG_SOF] ##0 rd_data_reg[`HTCEF_FLAG_SOF])
    else $error("flag read altered flag");
  rsvd_zero_a: assert property (@(posedge clock) disable iff (reset)
    rd_valid_reg && $past(cmd.code) == `HTCEF_RD_FLAGS
      |-> rd_data_reg[15:7] == `HTCEF_ZERO9 && !rd_data_reg[`HTCEF_FLAG_RSVD])
    else $error("reserved flag bits nonzero");
  pin_off_a: assert property (@(posedge clock) disable iff (reset)
    !irq_pin_on |=> !host_irq_pin_reg)
    else $error("interrupt pin active while disabled");
  pin_gate_a: assert property (@(posedge clock) disable iff (reset)
    (irq_pin_on && (flags & mask_reg) != 7'h00) |=> host_irq_pin_reg)
    else $error("enabled flag did not reach pin");
  mask_reset_a: assert property (@(posedge clock)
    $fell(reset) |-> mask_reg == `HTCEF_ZERO7)
    else $error("mask not zero after reset");
endmodule
`default_nettype wire

// [dv/htcef_host_model.sv]
// Behavioural host processor that issues commands to the transfer count and event flag block.
// Assumes the bench calls its tasks and that answers come on the same clock.
`timescale 1ns/1ns
`default_nettype none
module htcef_host_model
  import htcef_pkg::*;
(
  input  wire logic        clock,    // System clock.
  input  wire logic [15:0] rd_data,  // Read answer.
  input  wire logic        rd_valid, // Read answer valid.
  output var  htcef_cmd_t  cmd       // Command to the block.
);
  initial cmd = '0;

  // Each command ends on an edge of its own, so a following call never
  // raises the strobe at the same edge where this one dropped it.
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clock);
    cmd <= '{strobe: 1'b1, code: code, wdata: data};
    @(posedge clock);
    cmd <= '0;
  endtask

  task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic ok);
    int i;
    @(posedge clock);
    cmd <= '{strobe: 1'b1, code: code, wdata: 16'h0000};
    @(posedge clock);
    cmd <= '0;
    ok = 1'b0;
    data = 16'h0000;
    for (i = 0; i < 4 && !ok; i++) begin
      #1;
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        data = rd_data;
      end else begin
        @(posedge clock);
      end
    end
  endtask
endmodule
`default_nettype wire

// [dv/htcef_top_tb.sv]
// Self-checking bench for the transfer count and event flag block.
// Assumes the host model drives the command port and the bench drives all other inputs.
`timescale 1ns/1ns
`default_nettype none
`include "htcef_defs.svh"
module htcef_top_tb
  import htcef_pkg::*;
();
  htcef_cmd_t  cmd;
  htcef_evt_t  evt         = '0;
  logic        clock       = 1'b0;
  logic        reset       = 1'b1;
  logic        irq_pin_on  = 1'b0;
  logic        xfer_beat   = 1'b0;
  logic        ext_end_pin = 1'b0;
  logic [1:0]  beat_bytes  = 2'h2;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        irq;
  logic        xfer_end;
  logic        fill_upd;
  logic        dma_run;
  logic        seen;
  int          failures    = 0;
  int          num_checks  = 0;

  always #20 clock = ~clock;

  htcef_top dut_u (.clock(clock), .reset(reset), .cmd(cmd), .evt(evt),
    .irq_pin_on(irq_pin_on), .xfer_beat(xfer_beat), .beat_bytes(beat_bytes),
    .ext_end_pin(ext_end_pin), .rd_data_reg(rd_data), .rd_valid_reg(rd_valid),
    .host_irq_pin_reg(irq), .xfer_end_reg(xfer_end), .fill_update_reg(fill_upd),
    .dma_run_reg(dma_run));

  htcef_host_model host_u (.clock(clock), .rd_data(rd_data), .rd_valid(rd_valid), .cmd(cmd));

  task automatic stop_test();
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    host_u.rd(code, d, ok);
    check({15'h0000, ok}, 16'h0001);
    check(d, exp);
  endtask

  task automatic beats(input int k, input logic [1:0] nb);
    repeat (k) begin
      @(posedge clock);
      xfer_beat  <= 1'b1;
      beat_bytes <= nb;
    end
    @(posedge clock);
    xfer_beat <= 1'b0;
  endtask

  // The end pulse stands one cycle, so it is looked for after every edge.
  task automatic wait_end(input int n);
    seen = 1'b0;
    repeat (n) begin
      #1;
      if (xfer_end === 1'b1 && !seen) begin
        seen = 1'b1;
        check({15'h0000, fill_upd}, 16'h0001);
      end
      @(posedge clock);
    end
  endtask

  task automatic pin_is(input logic exp);
    repeat (2) @(posedge clock);
    #1;
    check({15'h0000, irq}, {15'h0000, exp});
  endtask

  task automatic reset_vals();
    rd_chk(`HTCEF_RD_COUNT, 16'h0000);
    rd_chk(`HTCEF_RD_FLAGS, 16'h0000);
    rd_chk(`HTCEF_RD_MASK, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
  endtask

  task automatic count_rw();
    host_u.wr(`HTCEF_WR_COUNT, 16'h1000);
    rd_chk(`HTCEF_RD_COUNT, 16'h1000);
    host_u.wr(`HTCEF_WR_COUNT, 16'h0800);
    rd_chk(`HTCEF_RD_COUNT, 16'h0800);
    host_u.wr(`HTCEF_WR_COUNT, 16'h0000);
  endtask

  task automatic pio_end();
    @(posedge clock);
    irq_pin_on <= 1'b1;
    host_u.wr(`HTCEF_WR_MASK, 16'h0004);
    host_u.wr(`HTCEF_WR_COUNT, 16'h0003);
    beats(2, 2'h2);
    wait_end(4);
    check({15'h0000, seen}, 16'h0001);
    pin_is(1'b1);
    rd_chk(`HTCEF_RD_FLAGS, 16'h0004);
    rd_chk(`HTCEF_RD_FLAGS, 16'h0004);
    @(posedge clock);
    irq_pin_on <= 1'b0;
    pin_is(1'b0);
    host_u.wr(`HTCEF_WR_FLAGS, 16'h0004);
    rd_chk(`HTCEF_RD_FLAGS, 16'h0000);
  endtask

  task automatic events();
    host_u.wr(`HTCEF_WR_MASK, 16'h007f);
    irq_pin_on <= 1'b1;
    evt        <= '1;
    @(posedge clock);
    evt <= '0;
    rd_chk(`HTCEF_RD_FLAGS, 16'h0073);
    pin_is(1'b1);
    host_u.wr(`HTCEF_WR_FLAGS, 16'hff88);
    rd_chk(`HTCEF_RD_FLAGS, 16'h0073);
    host_u.wr(`HTCEF_WR_MASK, 16'h0004);
    pin_is(1'b0);
    rd_chk(`HTCEF_RD_MASK, 16'h0004);
    host_u.wr(`HTCEF_WR_FLAGS, 16'h00ff);
    rd_chk(`HTCEF_RD_FLAGS, 16'h0000);
  endtask

  task automatic dma_runs();
    host_u.wr(`HTCEF_WR_COUNT, 16'h0004);
    host_u.wr(`HTCEF_WR_DMA, 16'h0014);
    #1;
    check({15'h0000, dma_run}, 16'h0001);
    beats(2, 2'h2);
    wait_end(4);
    check({15'h0000, seen}, 16'h0001);
    check({15'h0000, dma_run}, 16'h0000);
    rd_chk(`HTCEF_RD_DMA, 16'h0004);
    host_u.wr(`HTCEF_WR_DMA, 16'h0010);
    beats(4, 2'h2);
    wait_end(4);
    check({15'h0000, seen}, 16'h0000);
    ext_end_pin <= 1'b1;
    wait_end(10);
    check({15'h0000, seen}, 16'h0001);
    check({15'h0000, dma_run}, 16'h0000);
    ext_end_pin <= 1'b0;
    rd_chk(`HTCEF_RD_FLAGS, 16'h0004);
  endtask

  // Single-byte beats, then an external-end DMA that software aborts before the pin moves.
  task automatic odd_abort();
    host_u.wr(`HTCEF_WR_COUNT, 16'h0003);
    beats(3, 2'h1);
    wait_end(4);
    check({15'h0000, seen}, 16'h0001);
    host_u.wr(`HTCEF_WR_DMA, 16'h0010);
    #1;
    check({15'h0000, dma_run}, 16'h0001);
    host_u.wr(`HTCEF_WR_DMA, 16'h0000);
    #1;
    check({15'h0000, dma_run}, 16'h0000);
    @(posedge clock);
    ext_end_pin <= 1'b1;
    wait_end(10);
    check({15'h0000, seen}, 16'h0000);
    ext_end_pin <= 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    reset_vals();
    count_rw();
    pio_end();
    events();
    dma_runs();
    odd_abort();
    stop_test();
  end
endmodule
`default_nettype wire
